// [smao_pkg.sv]
// constants shared by both ends of the automatic off-line and attribute page link
`default_nettype none
package smao_pkg;
	localparam logic [7:0] SUB_AUTO_OFFL = 8'hdb;
	localparam logic [7:0] SUB_READ_VALS = 8'hd0;
	localparam logic [7:0] CNT_AUTO_OFF = 8'h00;
	localparam logic [7:0] CNT_AUTO_ON = 8'hf8;
	localparam int ADDR_W = 9;
	localparam int NUM_ENT = 30;
	localparam logic [8:0] ENT_BYTES = 9'h00c;
	localparam logic [15:0] REV_WORD = 16'h0010;
	localparam logic [8:0] OFF_REV = 9'h000;
	localparam logic [8:0] OFF_ENT0 = 9'h002;
	localparam logic [8:0] OFF_ENT_LAST = 9'h15e;
	localparam logic [8:0] OFF_OFFL_STAT = 9'h16a;
	localparam logic [8:0] OFF_ST_STAT = 9'h16b;
	localparam logic [8:0] OFF_SECS = 9'h16c;
	localparam logic [8:0] OFF_CAP_OFFL = 9'h16f;
	localparam logic [8:0] OFF_CAP_SMART = 9'h170;
	localparam logic [8:0] OFF_CAP_ERR = 9'h172;
	localparam logic [8:0] OFF_CHKPT = 9'h173;
	localparam logic [8:0] OFF_SHORT = 9'h174;
	localparam logic [8:0] OFF_EXT = 9'h175;
	localparam logic [8:0] OFF_EXT_WORD = 9'h177;
	localparam logic [8:0] OFF_CKSUM = 9'h1ff;
	localparam logic [3:0] E_ID = 4'h0;
	localparam logic [3:0] E_FLAGS = 4'h1;
	localparam logic [3:0] E_VAL = 4'h3;
	localparam logic [7:0] CAP_OFFL = 8'h1b;
	localparam logic [15:0] CAP_SMART = 16'h0003;
	localparam logic [7:0] CAP_ERR = 8'h01;
	localparam logic [7:0] EXT_ESC = 8'hff;
	localparam logic [7:0] VAL_MIN = 8'h01;
	localparam logic [7:0] VAL_MAX = 8'hfd;
	localparam logic [7:0] VAL_RST = 8'h64;
	localparam int OFFL_AUTO_BIT = 7;
	localparam logic [7:0] FLAG_PREFAIL = 8'h01;
	localparam logic [7:0] FLAG_ONLINE = 8'h02;
	// active ids in slot order, zero marks an unused slot
	localparam logic [7:0] ATTR_ID [NUM_ENT] = '{
		8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0c,
		8'hc0, 8'hc1, 8'hc2, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// low flag byte per slot; the high flag byte is always zero
	localparam logic [7:0] ATTR_FLAGS [NUM_ENT] = '{
		8'h03, 8'h03, 8'h03, 8'h02, 8'h03, 8'h03, 8'h03, 8'h02, 8'h03, 8'h02,
		8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
endpackage : smao_pkg
`default_nettype wire

// [smao_if.sv]
// command and page-stream link between the host controller and the device
`default_nettype none
interface smao_if;
	logic cmd_req; // one-cycle command strobe
	logic [7:0] cmd_sub; // subcommand code
	logic [7:0] cmd_cnt; // sector count loaded with the command strobe
	logic cmd_done; // one-cycle completion pulse
	logic cmd_abort; // error flag, valid with cmd_done
	logic rd_vld; // page byte valid
	logic [7:0] rd_byte; // page byte
	logic rd_last; // last page byte
	modport host (output cmd_req, cmd_sub, cmd_cnt,
		input cmd_done, cmd_abort, rd_vld, rd_byte, rd_last);
	modport dev (input cmd_req, cmd_sub, cmd_cnt,
		output cmd_done, cmd_abort, rd_vld, rd_byte, rd_last);
endinterface : smao_if
`default_nettype wire

// [smao_dev.sv]
// device end: auto off-line enable control and attribute page streaming
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`default_nettype none
module smao_dev (
	input wire logic clk_i, // 40 mhz clock
	input wire logic rst_n_i, // synchronous reset, active low
	smao_if.dev lnk, // link to the host controller
	input wire logic val_we_i, // write a normalized value
	input wire logic [4:0] val_idx_i, // slot of that value
	input wire logic [7:0] val_i, // raw normalized value, clamped on write
	input wire logic [6:0] offl_code_i, // off-line status code, bits 6:0
	input wire logic [7:0] st_stat_i, // self-test execution status
	input wire logic [15:0] secs_i, // seconds to finish off-line collection
	input wire logic [7:0] chkpt_i, // self-test failure checkpoint
	input wire logic [7:0] short_min_i, // short self-test minutes
	input wire logic [15:0] ext_min_i, // extended self-test minutes
	input wire logic pwr_evt_i, // power-on, power-off or recovery pulse
	input wire logic collect_done_i, // collection pass finished pulse
	output logic auto_en_o, // auto collection enabled
	output logic collect_run_o, // start or resume collection
	output logic save_req_o // save attributes to non-volatile memory
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} smao_dst_t;

	smao_dst_t st_q, st_d;
	logic auto_q, auto_d;
	logic run_q, run_d;
	logic save_q, save_d;
	logic done_q, done_d;
	logic abort_q, abort_d;
	logic vld_q, vld_d;
	logic last_q, last_d;
	logic [7:0] byte_q, byte_d;
	logic [7:0] sum_q, sum_d;
	logic [8:0] addr_q, addr_d;
	logic [7:0] val_q [smao_pkg::NUM_ENT];
	logic [7:0] val_clamp;
	logic [7:0] pb;
	logic [8:0] rel;
	logic [4:0] ent;
	logic [3:0] pos;

	// values outside 01h..fdh are pulled to the nearest limit
	always_comb
	begin
		val_clamp = val_i;
		if (val_i < smao_pkg::VAL_MIN)
			val_clamp = smao_pkg::VAL_MIN;
		else if (val_i > smao_pkg::VAL_MAX)
			val_clamp = smao_pkg::VAL_MAX;
	end

	// value table; slots past the active list still store but never show
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < smao_pkg::NUM_ENT; i++)
				val_q[i] <= smao_pkg::VAL_RST;
		end
		else if (val_we_i && (val_idx_i < 5'(smao_pkg::NUM_ENT)))
			val_q[val_idx_i] <= val_clamp;
	end

	// byte at the current page address, low byte first for every word
	always_comb
	begin
		rel = addr_q - smao_pkg::OFF_ENT0;
		ent = 5'(rel / smao_pkg::ENT_BYTES);
		pos = 4'(rel % smao_pkg::ENT_BYTES);
		pb = 8'h00;
		if (addr_q == smao_pkg::OFF_REV)
			pb = smao_pkg::REV_WORD[7:0];
		else if (addr_q == smao_pkg::OFF_REV + 9'h001)
			pb = smao_pkg::REV_WORD[15:8];
		else if (addr_q < smao_pkg::OFF_ENT_LAST + smao_pkg::ENT_BYTES)
		begin
			if (smao_pkg::ATTR_ID[ent] != 8'h00)
			begin
				if (pos == smao_pkg::E_ID)
					pb = smao_pkg::ATTR_ID[ent];
				else if (pos == smao_pkg::E_FLAGS)
					pb = smao_pkg::ATTR_FLAGS[ent];
				else if (pos == smao_pkg::E_VAL)
					pb = val_q[ent];
			end
		end
		else
		begin
			unique case (addr_q)
				smao_pkg::OFF_OFFL_STAT: pb = {auto_q, offl_code_i};
				smao_pkg::OFF_ST_STAT: pb = st_stat_i;
				smao_pkg::OFF_SECS: pb = secs_i[7:0];
				smao_pkg::OFF_SECS + 9'h001: pb = secs_i[15:8];
				smao_pkg::OFF_CAP_OFFL: pb = smao_pkg::CAP_OFFL;
				smao_pkg::OFF_CAP_SMART: pb = smao_pkg::CAP_SMART[7:0];
				smao_pkg::OFF_CAP_SMART + 9'h001: pb = smao_pkg::CAP_SMART[15:8];
				smao_pkg::OFF_CAP_ERR: pb = smao_pkg::CAP_ERR;
				smao_pkg::OFF_CHKPT: pb = chkpt_i;
				smao_pkg::OFF_SHORT: pb = short_min_i;
				// escape value tells the host to read the word instead
				smao_pkg::OFF_EXT: pb = (ext_min_i >= 16'(smao_pkg::EXT_ESC)) ?
					smao_pkg::EXT_ESC : ext_min_i[7:0];
				smao_pkg::OFF_EXT_WORD: pb = ext_min_i[7:0];
				smao_pkg::OFF_EXT_WORD + 9'h001: pb = ext_min_i[15:8];
				// reserved and vendor areas up to the checksum read zero
				default: pb = 8'h00;
			endcase
		end
	end

	// command decode and page streaming
	always_comb
	begin
		st_d = st_q;
		auto_d = auto_q;
		done_d = 1'b0;
		abort_d = 1'b0;
		vld_d = 1'b0;
		last_d = 1'b0;
		byte_d = byte_q;
		sum_d = sum_q;
		addr_d = addr_q;
		unique case (st_q)
			ST_IDLE:
			begin
				if (lnk.cmd_req)
				begin
					done_d = 1'b1;
					if (lnk.cmd_sub == smao_pkg::SUB_AUTO_OFFL)
					begin
						if (lnk.cmd_cnt == smao_pkg::CNT_AUTO_OFF)
							auto_d = 1'b0;
						else if (lnk.cmd_cnt == smao_pkg::CNT_AUTO_ON)
							auto_d = 1'b1;
						else
							abort_d = 1'b1; // setting kept
					end
					else if (lnk.cmd_sub == smao_pkg::SUB_READ_VALS)
					begin
						// completion is reported with the last byte instead
						done_d = 1'b0;
						addr_d = 9'h000;
						sum_d = 8'h00;
						st_d = ST_SEND;
					end
					else
						abort_d = 1'b1;
				end
			end
			ST_SEND:
			begin
				vld_d = 1'b1;
				addr_d = addr_q + 9'h001;
				if (addr_q == smao_pkg::OFF_CKSUM)
				begin
					byte_d = 8'h00 - sum_q;
					last_d = 1'b1;
					done_d = 1'b1;
					st_d = ST_IDLE;
				end
				else
				begin
					byte_d = pb;
					sum_d = sum_q + pb;
				end
			end
		endcase
	end

	// collection runs while enabled; saves follow a pass while enabled, or a power event
	always_comb
	begin
		run_d = auto_q;
		save_d = (auto_q && collect_done_i) || pwr_evt_i;
	end

	// register every next value
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st_q <= ST_IDLE;
			auto_q <= 1'b0;
			run_q <= 1'b0;
			save_q <= 1'b0;
			done_q <= 1'b0;
			abort_q <= 1'b0;
			vld_q <= 1'b0;
			last_q <= 1'b0;
			byte_q <= 8'h00;
			sum_q <= 8'h00;
			addr_q <= 9'h000;
		end
		else
		begin
			st_q <= st_d;
			auto_q <= auto_d;
			run_q <= run_d;
			save_q <= save_d;
			done_q <= done_d;
			abort_q <= abort_d;
			vld_q <= vld_d;
			last_q <= last_d;
			byte_q <= byte_d;
			sum_q <= sum_d;
			addr_q <= addr_d;
		end
	end

	assign lnk.cmd_done = done_q;
	assign lnk.cmd_abort = abort_q;
	assign lnk.rd_vld = vld_q;
	assign lnk.rd_byte = byte_q;
	assign lnk.rd_last = last_q;
	assign auto_en_o = auto_q;
	assign collect_run_o = run_q;
	assign save_req_o = save_q;
endmodule : smao_dev
`default_nettype wire

// [smao_host.sv]
// host end: issues the two subcommands and captures the attribute page
`default_nettype none
module smao_host (
	input wire logic clk_i, // 40 mhz clock
	input wire logic rst_n_i, // synchronous reset, active low
	smao_if.host lnk, // link to the device
	input wire logic auto_set_i, // pulse: send the auto off-line subcommand
	input wire logic [7:0] auto_cnt_i, // sector count to load with it
	input wire logic read_i, // pulse: read the attribute page
	input wire logic [8:0] pg_addr_i, // captured page byte to look at
	output logic busy_o, // command outstanding
	output logic done_o, // command finished pulse
	output logic abort_o, // device answered with abort, held to next command
	output logic sum_ok_o, // last page summed to zero
	output logic [15:0] ext_min_o, // extended self-test minutes
	output logic [7:0] pg_data_o // captured byte, one cycle after pg_addr_i
);
	typedef enum logic [1:0] {
		HS_IDLE = 2'b01,
		HS_WAIT = 2'b10
	} smao_hst_t;

	smao_hst_t st_q, st_d;
	logic req_q, req_d;
	logic [7:0] sub_q, sub_d;
	logic [7:0] cnt_q, cnt_d;
	logic done_q, done_d;
	logic abort_q, abort_d;
	logic ok_q, ok_d;
	logic [15:0] ext_q, ext_d;
	logic [7:0] sum_q, sum_d;
	logic [8:0] wa_q, wa_d;
	logic [7:0] pg_q;
	logic [7:0] page [512];

	// sequencing; a new order is only taken while idle
	always_comb
	begin
		st_d = st_q;
		req_d = 1'b0;
		sub_d = sub_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		abort_d = abort_q;
		ok_d = ok_q;
		ext_d = ext_q;
		sum_d = sum_q;
		wa_d = wa_q;
		unique case (st_q)
			HS_IDLE:
			begin
				if (auto_set_i)
				begin
					req_d = 1'b1;
					sub_d = smao_pkg::SUB_AUTO_OFFL;
					cnt_d = auto_cnt_i;
					st_d = HS_WAIT;
				end
				else if (read_i)
				begin
					req_d = 1'b1;
					sub_d = smao_pkg::SUB_READ_VALS;
					cnt_d = 8'h01;
					sum_d = 8'h00;
					wa_d = 9'h000;
					st_d = HS_WAIT;
				end
			end
			HS_WAIT:
			begin
				if (lnk.rd_vld)
				begin
					sum_d = sum_q + lnk.rd_byte;
					wa_d = wa_q + 9'h001;
				end
				if (lnk.rd_vld && lnk.rd_last)
				begin
					ok_d = ((sum_q + lnk.rd_byte) == 8'h00);
					// escape byte points to the word stored low byte first
					ext_d = (page[smao_pkg::OFF_EXT] == smao_pkg::EXT_ESC) ?
						{page[smao_pkg::OFF_EXT_WORD + 9'h001],
						page[smao_pkg::OFF_EXT_WORD]} :
						{8'h00, page[smao_pkg::OFF_EXT]};
				end
				if (lnk.cmd_done)
				begin
					done_d = 1'b1;
					abort_d = lnk.cmd_abort;
					st_d = HS_IDLE;
				end
			end
		endcase
	end

	// page memory; writes only during a transfer
	always_ff @(posedge clk_i)
	begin
		if ((st_q == HS_WAIT) && lnk.rd_vld)
			page[wa_q] <= lnk.rd_byte;
		pg_q <= page[pg_addr_i];
	end

	// register every next value
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st_q <= HS_IDLE;
			req_q <= 1'b0;
			sub_q <= 8'h00;
			cnt_q <= 8'h00;
			done_q <= 1'b0;
			abort_q <= 1'b0;
			ok_q <= 1'b0;
			ext_q <= 16'h0000;
			sum_q <= 8'h00;
			wa_q <= 9'h000;
		end
		else
		begin
			st_q <= st_d;
			req_q <= req_d;
			sub_q <= sub_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			abort_q <= abort_d;
			ok_q <= ok_d;
			ext_q <= ext_d;
			sum_q <= sum_d;
			wa_q <= wa_d;
		end
	end

	assign lnk.cmd_req = req_q;
	assign lnk.cmd_sub = sub_q;
	assign lnk.cmd_cnt = cnt_q;
	assign busy_o = (st_q == HS_WAIT);
	assign done_o = done_q;
	assign abort_o = abort_q;
	assign sum_ok_o = ok_q;
	assign ext_min_o = ext_q;
	assign pg_data_o = pg_q;
endmodule : smao_host
`default_nettype wire

// [smao_props.sv]
// assertions on the command and page link between host and device
`default_nettype none
module smao_props (
	input wire logic clk_i, // link clock
	input wire logic rst_n_i, // sync reset, active low
	input wire logic cmd_req, // command strobe
	input wire logic [7:0] cmd_sub, // subcommand
	input wire logic [7:0] cmd_cnt, // sector count
	input wire logic cmd_done, // completion
	input wire logic cmd_abort, // error flag
	input wire logic rd_vld, // byte valid
	input wire logic [7:0] rd_byte, // page byte
	input wire logic rd_last // last byte
);
	logic [9:0] idx_q, idx_d;
	logic [7:0] sum_q, sum_d;
	logic auto_c;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// byte index and running sum restart between pages, so a short page shows
	always_comb
	begin
		idx_d = rd_vld ? idx_q + 10'h001 : 10'h000;
		sum_d = rd_vld ? sum_q + rd_byte : 8'h00;
	end
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			idx_q <= 10'h000;
			sum_q <= 8'h00;
		end
		else
		begin
			idx_q <= idx_d;
			sum_q <= sum_d;
		end
	end
	// requests during a page send are ignored by the device
	assign auto_c = cmd_req && !rd_vld && cmd_sub == smao_pkg::SUB_AUTO_OFFL;
	a_auto_done: assert property (auto_c |=> cmd_done)
		else $error("auto order not completed");
	a_bad_cnt_abort: assert property (auto_c && cmd_cnt != 8'h00 && cmd_cnt != 8'hf8
		|=> cmd_abort) else $error("odd count not aborted");
	a_good_cnt_ok: assert property (auto_c && (cmd_cnt == 8'h00 || cmd_cnt == 8'hf8)
		|=> !cmd_abort) else $error("valid count aborted");
	a_abort_with_done: assert property (cmd_abort |-> cmd_done)
		else $error("abort without done");
	// the device registers the first byte one cycle after it takes the order
	a_read_starts: assert property (cmd_req && !rd_vld
		&& cmd_sub == smao_pkg::SUB_READ_VALS |=> !rd_vld ##1 rd_vld [*8])
		else $error("page not streaming");
	a_last_len: assert property (rd_last |-> rd_vld && cmd_done && idx_q == 10'h1ff)
		else $error("page length wrong");
	a_page_ends: assert property (rd_last |=> !rd_vld)
		else $error("valid after last byte");
	a_rev_word: assert property (rd_vld && idx_q < 10'h002
		|-> rd_byte == (idx_q == 10'h000 ? 8'h10 : 8'h00)) else $error("revision word wrong");
	a_cap_fixed: assert property (rd_vld && idx_q == 10'h16f |-> rd_byte == 8'h1b)
		else $error("capability byte wrong");
	a_unused_zero: assert property (rd_vld && idx_q >= 10'h0ce && idx_q < 10'h16a
		|-> rd_byte == 8'h00) else $error("unused slot not zero");
	a_checksum: assert property (rd_last |-> sum_q + rd_byte == 8'h00)
		else $error("checksum wrong");
endmodule : smao_props
`default_nettype wire

// [smart_auto_offline_attribute_page_tb.sv]
// self-checking bench: host and device ends joined over the link
`default_nettype none
module smart_auto_offline_attribute_page_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic val_we_i = 1'b0;
	logic [4:0] val_idx_i = 5'h00;
	logic [7:0] val_i = 8'h00;
	logic [6:0] offl_code_i = 7'h05;
	logic [7:0] st_stat_i = 8'hf3;
	logic [15:0] secs_i = 16'h1234;
	logic [7:0] chkpt_i = 8'h5a;
	logic [7:0] short_min_i = 8'h02;
	logic [15:0] ext_min_i = 16'h0123;
	logic pwr_evt_i = 1'b0;
	logic collect_done_i = 1'b0;
	logic auto_set_i = 1'b0;
	logic [7:0] auto_cnt_i = 8'h00;
	logic read_i = 1'b0;
	logic [8:0] pg_addr_i = 9'h000;
	logic auto_en_o, collect_run_o, save_req_o, busy_o, done_o, abort_o, sum_ok_o;
	logic [15:0] ext_min_o;
	logic [7:0] pg_data_o;
	logic [7:0] vexp [30];
	logic [7:0] wpg [512];
	int wi = 0;
	int n_mismatch = 0;
	int check_count = 0;
	always #12.5 clk_i = ~clk_i;
	smao_if u_smao_if ();
	smao_dev u_smao_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .lnk(u_smao_if),
		.val_we_i(val_we_i), .val_idx_i(val_idx_i), .val_i(val_i), .offl_code_i(offl_code_i),
		.st_stat_i(st_stat_i), .secs_i(secs_i), .chkpt_i(chkpt_i), .short_min_i(short_min_i),
		.ext_min_i(ext_min_i), .pwr_evt_i(pwr_evt_i), .collect_done_i(collect_done_i),
		.auto_en_o(auto_en_o), .collect_run_o(collect_run_o), .save_req_o(save_req_o));
	smao_host u_smao_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .lnk(u_smao_if),
		.auto_set_i(auto_set_i), .auto_cnt_i(auto_cnt_i), .read_i(read_i),
		.pg_addr_i(pg_addr_i), .busy_o(busy_o), .done_o(done_o), .abort_o(abort_o),
		.sum_ok_o(sum_ok_o), .ext_min_o(ext_min_o), .pg_data_o(pg_data_o));
	smao_props u_smao_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_req(u_smao_if.cmd_req),
		.cmd_sub(u_smao_if.cmd_sub), .cmd_cnt(u_smao_if.cmd_cnt),
		.cmd_done(u_smao_if.cmd_done), .cmd_abort(u_smao_if.cmd_abort),
		.rd_vld(u_smao_if.rd_vld), .rd_byte(u_smao_if.rd_byte), .rd_last(u_smao_if.rd_last));
	// capture the page straight off the wire, independent of the host's copy;
	// sampled mid-cycle so the registered link outputs have settled
	always @(negedge clk_i)
	begin
		if (u_smao_if.rd_vld !== 1'b1)
			wi = 0;
		else
		begin
			wpg[wi] = u_smao_if.rd_byte;
			wi++;
		end
	end
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	// bounded wait for the host's done pulse, sampled once edges have settled
	task automatic wait_done();
		int i;
		for (i = 0; i < 600; i++)
		begin
			@(posedge clk_i);
			#1;
			if (done_o === 1'b1)
				break;
		end
		chk(i < 600, "no done");
	endtask : wait_done
	task automatic wr_val(input logic [4:0] idx, input logic [7:0] v);
		@(posedge clk_i);
		val_we_i <= 1'b1;
		val_idx_i <= idx;
		val_i <= v;
		@(posedge clk_i);
		val_we_i <= 1'b0;
	endtask : wr_val
	task automatic t_auto(input logic [7:0] c, input logic en, input logic ab);
		@(posedge clk_i);
		auto_set_i <= 1'b1;
		auto_cnt_i <= c;
		@(posedge clk_i);
		auto_set_i <= 1'b0;
		wait_done();
		@(posedge clk_i);
		#1;
		chk(auto_en_o === en && abort_o === ab, "auto enable or abort");
		chk(collect_run_o === en, "collection run");
	endtask : t_auto
	task automatic t_save(input logic en);
		@(posedge clk_i);
		pwr_evt_i <= 1'b1;
		@(posedge clk_i);
		pwr_evt_i <= 1'b0;
		collect_done_i <= 1'b1;
		#1 chk(save_req_o === 1'b1, "power save");
		@(posedge clk_i);
		collect_done_i <= 1'b0;
		#1 chk(save_req_o === en, "collection save");
	endtask : t_save
	// expected page byte, from the package layout and the levels driven here
	function automatic logic [7:0] exp_b(input logic [8:0] a, input logic en);
		int e;
		int o;
		e = (int'(a) - 2) / 12;
		o = (int'(a) - 2) % 12;
		if (a < 9'h002)
			return a[0] ? smao_pkg::REV_WORD[15:8] : smao_pkg::REV_WORD[7:0];
		if (a < 9'h16a)
		begin
			if (smao_pkg::ATTR_ID[e] === 8'h00 || o == 2 || o > 3)
				return 8'h00;
			return o == 0 ? smao_pkg::ATTR_ID[e] : o == 1 ? smao_pkg::ATTR_FLAGS[e] : vexp[e];
		end
		case (a)
			9'h16a: return {en, offl_code_i};
			9'h16b: return st_stat_i;
			9'h16c: return secs_i[7:0];
			9'h16d: return secs_i[15:8];
			9'h16f: return 8'h1b;
			9'h170: return 8'h03;
			9'h172: return 8'h01;
			9'h173: return chkpt_i;
			9'h174: return short_min_i;
			9'h175: return ext_min_i > 16'h00fe ? 8'hff : ext_min_i[7:0];
			9'h177: return ext_min_i[7:0];
			9'h178: return ext_min_i[15:8];
			default: return 8'h00;
		endcase
	endfunction : exp_b
	task automatic t_read(input logic en);
		int s;
		logic [7:0] e;
		@(posedge clk_i);
		read_i <= 1'b1;
		@(posedge clk_i);
		read_i <= 1'b0;
		#1 chk(busy_o === 1'b1, "host not busy");
		wait_done();
		chk(busy_o === 1'b0, "host still busy");
		chk(sum_ok_o === 1'b1, "page sum");
		chk(ext_min_o === ext_min_i, "extended minutes");
		s = 0;
		for (int a = 0; a < 511; a++)
		begin
			e = exp_b(a[8:0], en);
			s = s + e;
			@(posedge clk_i);
			pg_addr_i <= a[8:0];
			@(posedge clk_i);
			#1;
			chk(pg_data_o === e, $sformatf("byte %0h", a));
			chk(wpg[a] === e, $sformatf("wire %0h", a));
		end
		chk(wpg[511] === 8'h00 - s[7:0], "checksum");
	endtask : t_read
	initial
	begin
		for (int i = 0; i < 30; i++)
			vexp[i] = smao_pkg::VAL_RST;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		wr_val(5'h00, 8'h00);
		wr_val(5'h01, 8'hff);
		wr_val(5'h02, 8'h80);
		wr_val(5'h14, 8'h55);
		wr_val(5'h1e, 8'h11);
		vexp[0] = 8'h01; // clamped up
		vexp[1] = 8'hfd; // clamped down
		vexp[2] = 8'h80;
		t_auto(8'hf8, 1'b1, 1'b0);
		t_save(1'b1);
		t_read(1'b1);
		t_auto(8'h01, 1'b1, 1'b1);
		t_auto(8'h00, 1'b0, 1'b0);
		t_auto(8'hf1, 1'b0, 1'b1);
		t_save(1'b0);
		ext_min_i <= 16'h00fe;
		t_read(1'b0);
		ext_min_i <= 16'h00ff;
		t_read(1'b0);
		print_verdict();
	end
	// three page reads take about five thousand cycles
	initial
	begin
		#(25ns * 20000);
		n_mismatch++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		print_verdict();
	end
endmodule : smart_auto_offline_attribute_page_tb
`default_nettype wire
